// ---- rtl/mfs_defs.vh ----
`ifndef MFS_DEFS_VH
`define MFS_DEFS_VH
// Register byte offsets on the AXI4-Lite slave.
`define MFS_REG_CTRL 8'h00
`define MFS_REG_STATUS 8'h04
`define MFS_REG_PC_LOW 8'h08
`define MFS_REG_TBLP 8'h0C
`define MFS_REG_TBHP 8'h10
`define MFS_REG_TBL_HI 8'h14
`define MFS_REG_ACC 8'h18
`define MFS_REG_MEM 8'h1C
`define MFS_REG_INTST 8'h20
// Control register fields and reset values.
`define MFS_CTRL_RUN 0
`define MFS_CTRL_EMI 1
`define MFS_RUN_RST 1'h1
`define MFS_EMI_RST 1'h0
// Status register fields.
`define MFS_ST_C 0
`define MFS_ST_AC 1
`define MFS_ST_Z 2
`define MFS_ST_OV 3
`define MFS_STATUS_RST 4'h0
// Program memory vectors.
`define MFS_RESET_VECTOR 11'h000
`define MFS_INT_VECTOR 11'h004
// Stack depth default.
`define MFS_STACK_DEPTH 6
// Instruction classes in bits 15:12 of the instruction word.
`define MFS_CL_NOP 4'h0
`define MFS_CL_ALUI 4'h1
`define MFS_CL_ALUM 4'h2
`define MFS_CL_JUMP 4'h3
`define MFS_CL_CALL 4'h4
`define MFS_CL_RTN 4'h5
`define MFS_CL_RTNI 4'h6
`define MFS_CL_SKZ 4'h7
`define MFS_CL_SKNZ 4'h8
`define MFS_CL_SETLOW 4'h9
`define MFS_CL_TABRD 4'hA
// ALU function codes in bits 11:8.
`define MFS_FN_ADD 4'h0
`define MFS_FN_ADC 4'h1
`define MFS_FN_SUB 4'h2
`define MFS_FN_SBC 4'h3
`define MFS_FN_AND 4'h4
`define MFS_FN_OR 4'h5
`define MFS_FN_XOR 4'h6
`define MFS_FN_CPL 4'h7
`define MFS_FN_RR 4'h8
`define MFS_FN_RRC 4'h9
`define MFS_FN_RL 4'hA
`define MFS_FN_RLC 4'hB
`define MFS_FN_INC 4'hC
`define MFS_FN_DEC 4'hD
`define MFS_FN_DADJ 4'hE
`define MFS_FN_PASS 4'hF
// Bus responses.
`define MFS_RESP_OKAY 2'h0
`define MFS_RESP_SLVERR 2'h2
`endif

// ---- rtl/mfs_stack.v ----
`timescale 1ns/100ps
`include "mfs_defs.vh"
// Return-address stack; a push while full overwrites the oldest entry.
module mfs_stack #(
    parameter DEPTH = `MFS_STACK_DEPTH,
    parameter PW = 11
) (
    input wire core_clk_i, // System clock.
    input wire rst_n_i, // Asynchronous reset, active low.
    input wire push_i, // Push request.
    input wire pop_i, // Pop request.
    input wire [PW-1:0] data_i, // Value pushed.
    output wire [PW-1:0] top_o, // Most recent entry.
    output wire full_o // All levels in use.
);
    localparam SW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam CW = $clog2(DEPTH + 1);

    reg [PW-1:0] mem [0:DEPTH-1];
    reg [SW-1:0] wp;
    reg [CW-1:0] count;
    wire [SW-1:0] wp_dec;
    wire [SW-1:0] wp_inc;

    // Pointer arithmetic wraps around the ring of levels.
    assign wp_dec = (wp == {SW{1'b0}}) ? DEPTH[SW-1:0] - 1'b1 : wp - 1'b1;
    assign wp_inc = (wp == DEPTH[SW-1:0] - 1'b1) ? {SW{1'b0}} : wp + 1'b1;
    assign top_o = mem[wp_dec];
    assign full_o = (count == DEPTH[CW-1:0]);

    // Entry storage, written only on a push.
    always @(posedge core_clk_i)
    begin
        if (push_i)
        begin
            mem[wp] <= data_i;
        end
    end

    // Pointer and fill count; reset leaves the pointer at the top.
    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp <= {SW{1'b0}};
            count <= {CW{1'b0}};
        end
        else if (push_i)
        begin
            wp <= wp_inc;
            if (!full_o)
            begin
                count <= count + 1'b1;
            end
        end
        else if (pop_i && count != {CW{1'b0}})
        begin
            wp <= wp_dec;
            count <= count - 1'b1;
        end
    end
endmodule // mfs_stack

// ---- rtl/mfs_alu.v ----
`timescale 1ns/100ps
`include "mfs_defs.vh"
// Eight-bit ALU producing a result and the updated status flags.
module mfs_alu (
    input wire [3:0] fn_i, // Function code.
    input wire [7:0] a_i, // First operand.
    input wire [7:0] b_i, // Second operand.
    input wire [3:0] status_i, // Current flags.
    output reg [7:0] res_o, // Result.
    output reg [3:0] status_o // Updated flags.
);
    reg sub;
    reg ci;
    reg [7:0] bx;
    reg [8:0] sum;
    reg [4:0] nib;
    reg [8:0] da;

    always @*
    begin
        sub = (fn_i == `MFS_FN_SUB) || (fn_i == `MFS_FN_SBC);
        bx = sub ? ~b_i : b_i;
        ci = ((fn_i == `MFS_FN_ADC) || (fn_i == `MFS_FN_SBC)) ? status_i[`MFS_ST_C] : sub;
        sum = {1'b0, a_i} + {1'b0, bx} + {8'h00, ci};
        nib = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
        da = {1'b0, a_i};
        if (a_i[3:0] > 4'h9 || status_i[`MFS_ST_AC])
        begin
            da = da + 9'h006;
        end
        if (da[8] || da[7:4] > 4'h9 || status_i[`MFS_ST_C])
        begin
            da = da + 9'h060;
        end
        res_o = a_i;
        status_o = status_i;
        case (fn_i)
            `MFS_FN_ADD, `MFS_FN_ADC, `MFS_FN_SUB, `MFS_FN_SBC:
            begin
                res_o = sum[7:0];
                status_o[`MFS_ST_C] = sum[8];
                status_o[`MFS_ST_AC] = nib[4];
                status_o[`MFS_ST_OV] = (a_i[7] == bx[7]) && (sum[7] != a_i[7]);
            end
            `MFS_FN_AND: res_o = a_i & b_i;
            `MFS_FN_OR: res_o = a_i | b_i;
            `MFS_FN_XOR: res_o = a_i ^ b_i;
            `MFS_FN_CPL: res_o = ~a_i;
            `MFS_FN_RR: res_o = {a_i[0], a_i[7:1]};
            `MFS_FN_RRC:
            begin
                res_o = {status_i[`MFS_ST_C], a_i[7:1]};
                status_o[`MFS_ST_C] = a_i[0];
            end
            `MFS_FN_RL: res_o = {a_i[6:0], a_i[7]};
            `MFS_FN_RLC:
            begin
                res_o = {a_i[6:0], status_i[`MFS_ST_C]};
                status_o[`MFS_ST_C] = a_i[7];
            end
            `MFS_FN_INC: res_o = a_i + 8'h01;
            `MFS_FN_DEC: res_o = a_i - 8'h01;
            `MFS_FN_DADJ:
            begin
                res_o = da[7:0];
                status_o[`MFS_ST_C] = da[8] | status_i[`MFS_ST_C];
            end
            default: res_o = a_i;
        endcase
        // Rotates leave the zero flag alone.
        if (fn_i[3:2] != 2'h2)
        begin
            status_o[`MFS_ST_Z] = (res_o == 8'h00);
        end
    end
endmodule // mfs_alu

// ---- rtl/mfs_top.v ----
// Functional notes
// - Four non-overlapping phases form one cycle.
// - PC advances at T1 while fetching.
// - Fetch overlaps execute, one per cycle.
// - PC-changing instructions take two cycles.
// - Eleven-bit PC, low byte software visible.
// - Low byte write jumps in page, dummy.
// - Taken skip discards prefetch, dummy cycle.
// - Hidden stack holds only PC values.
// - Call/interrupt push, returns pop PC.
// - Reset points stack at its top.
// - Full stack latches interrupt, delays acknowledge.
// - Call on full stack loses oldest.
// - ALU ops write destination and status flags; skips leave status unchanged.
// - ALU arithmetic, logic, rotate, skip set.
// - Program memory 2K x 16 by PC.
// - Reset loads PC with vector.
// - Table read: low byte, high latch.
// - Table read takes two cycles.
`timescale 1ns/100ps
`include "mfs_defs.vh"
module mfs_top #(
    parameter STACK_DEPTH = `MFS_STACK_DEPTH,
    parameter [10:0] INT_VECTOR = `MFS_INT_VECTOR
) (
    input wire core_clk_i, // System clock.
    input wire rst_n_i, // Asynchronous reset, active low.
    input wire [7:0] s_awaddr_i, // AXI write address.
    input wire s_awvalid_i, // AXI write address valid.
    output reg s_awready_o, // AXI write address ready.
    input wire [31:0] s_wdata_i, // AXI write data.
    input wire [3:0] s_wstrb_i, // AXI write strobes.
    input wire s_wvalid_i, // AXI write data valid.
    output reg s_wready_o, // AXI write data ready.
    output reg [1:0] s_bresp_o, // AXI write response.
    output reg s_bvalid_o, // AXI write response valid.
    input wire s_bready_i, // AXI write response ready.
    input wire [7:0] s_araddr_i, // AXI read address.
    input wire s_arvalid_i, // AXI read address valid.
    output reg s_arready_o, // AXI read address ready.
    output reg [31:0] s_rdata_o, // AXI read data.
    output reg [1:0] s_rresp_o, // AXI read response.
    output reg s_rvalid_o, // AXI read valid.
    input wire s_rready_i, // AXI read ready.
    output reg [10:0] pmem_addr_o, // Program memory word address.
    output reg pmem_rd_o, // Program memory read strobe.
    input wire [15:0] pmem_rdata_i, // Program memory word.
    input wire int_req_i, // Interrupt request pulse.
    output reg int_ack_o, // Interrupt acknowledge pulse.
    output reg [3:0] phase_o // One-hot T1..T4 phase.
);
    localparam PH_T1 = 2'h0;
    localparam PH_T2 = 2'h1;
    localparam PH_T3 = 2'h2;
    localparam PH_T4 = 2'h3;

    // One-hot view of a phase code.
    function [3:0] ph_dec;
        input [1:0] ph;
        begin
            ph_dec = 4'h1 << ph;
        end
    endfunction

    reg [1:0] phase;
    reg [10:0] pc;
    reg [15:0] ir;
    reg ir_valid;
    reg [15:0] pre;
    reg pre_valid;
    reg [7:0] acc;
    reg [7:0] mem_reg;
    reg [3:0] status;
    reg run;
    reg emi;
    reg [7:0] tblp;
    reg [2:0] tbhp;
    reg [7:0] table_high_latch;
    reg tbl_pend;
    reg int_flag;
    reg low_pend;
    reg [7:0] low_val;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg w_lane0;
    reg [31:0] rd_word;
    reg rd_err;

    wire [1:0] next_phase;
    wire [3:0] cls;
    wire exec;
    wire take_low;
    wire ex;
    wire flow;
    wire alu_imm;
    wire [7:0] alu_a;
    wire [7:0] alu_b;
    wire [7:0] alu_res;
    wire [3:0] alu_st;
    wire skip_taken;
    wire int_go;
    wire stk_push;
    wire stk_pop;
    wire [10:0] stk_top;
    wire stk_full;
    wire [10:0] ret_addr;
    wire wr_go;
    wire [7:0] wa;
    wire low_wr;

    assign next_phase = run ? phase + 2'h1 : phase;
    assign cls = ir[15:12];
    // Execution happens on the T3 edge of the cycle after the fetch.
    assign exec = run && (phase == PH_T3) && ir_valid;
    assign take_low = run && (phase == PH_T3) && low_pend;
    assign ex = exec && !take_low;
    assign alu_imm = (cls == `MFS_CL_ALUI);
    assign alu_a = alu_imm ? acc : mem_reg;
    assign alu_b = alu_imm ? ir[7:0] : acc;
    assign skip_taken = ex && (((cls == `MFS_CL_SKZ) && alu_st[`MFS_ST_Z]) ||
                               ((cls == `MFS_CL_SKNZ) && !alu_st[`MFS_ST_Z]));
    assign flow = (cls == `MFS_CL_JUMP) || (cls == `MFS_CL_CALL) ||
                  (cls == `MFS_CL_RTN) || (cls == `MFS_CL_RTNI) ||
                  (cls == `MFS_CL_SETLOW) || (cls == `MFS_CL_TABRD) || skip_taken;
    assign int_go = ex && !flow && int_flag && emi && !stk_full;
    assign stk_push = (ex && (cls == `MFS_CL_CALL)) || int_go;
    assign stk_pop = ex && ((cls == `MFS_CL_RTN) || (cls == `MFS_CL_RTNI));
    // The prefetched word sits at pc - 1, which is where execution resumes.
    assign ret_addr = pc - 11'h001;
    assign wr_go = !s_awready_o && !s_wready_o && !s_bvalid_o;
    assign wa = {aw_addr[7:2], 2'h0};
    assign low_wr = wr_go && w_lane0 && (wa == `MFS_REG_PC_LOW);

    mfs_stack #(
        .DEPTH(STACK_DEPTH),
        .PW(11)
    ) u_stack (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .push_i(stk_push),
        .pop_i(stk_pop),
        .data_i(ret_addr),
        .top_o(stk_top),
        .full_o(stk_full)
    );

    mfs_alu u_alu (
        .fn_i(ir[11:8]),
        .a_i(alu_a),
        .b_i(alu_b),
        .status_i(status),
        .res_o(alu_res),
        .status_o(alu_st)
    );

    // Register read decode; the stack and PC high bits are not mapped.
    always @*
    begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        case ({s_araddr_i[7:2], 2'h0})
            `MFS_REG_CTRL: rd_word[1:0] = {emi, run};
            `MFS_REG_STATUS: rd_word[3:0] = status;
            `MFS_REG_PC_LOW: rd_word[7:0] = pc[7:0];
            `MFS_REG_TBLP: rd_word[7:0] = tblp;
            `MFS_REG_TBHP: rd_word[2:0] = tbhp;
            `MFS_REG_TBL_HI: rd_word[7:0] = table_high_latch;
            `MFS_REG_ACC: rd_word[7:0] = acc;
            `MFS_REG_MEM: rd_word[7:0] = mem_reg;
            `MFS_REG_INTST: rd_word[0] = int_flag;
            default: rd_err = 1'b1;
        endcase
    end

    // AXI4-Lite slave handshakes; one write and one read in flight.
    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_awready_o <= 1'b1;
            s_wready_o <= 1'b1;
            s_bvalid_o <= 1'b0;
            s_bresp_o <= `MFS_RESP_OKAY;
            s_arready_o <= 1'b1;
            s_rvalid_o <= 1'b0;
            s_rdata_o <= 32'h00000000;
            s_rresp_o <= `MFS_RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (s_awvalid_i && s_awready_o)
            begin
                aw_addr <= s_awaddr_i;
                s_awready_o <= 1'b0;
            end
            if (s_wvalid_i && s_wready_o)
            begin
                w_data <= s_wdata_i;
                w_lane0 <= s_wstrb_i[0];
                s_wready_o <= 1'b0;
            end
            if (wr_go)
            begin
                s_bvalid_o <= 1'b1;
                s_bresp_o <= (wa > `MFS_REG_INTST) ? `MFS_RESP_SLVERR : `MFS_RESP_OKAY;
            end
            if (s_bvalid_o && s_bready_i)
            begin
                s_bvalid_o <= 1'b0;
                s_awready_o <= 1'b1;
                s_wready_o <= 1'b1;
            end
            if (s_arvalid_i && s_arready_o)
            begin
                s_arready_o <= 1'b0;
                s_rvalid_o <= 1'b1;
                s_rdata_o <= rd_word;
                s_rresp_o <= rd_err ? `MFS_RESP_SLVERR : `MFS_RESP_OKAY;
            end
            if (s_rvalid_o && s_rready_i)
            begin
                s_rvalid_o <= 1'b0;
                s_arready_o <= 1'b1;
            end
        end
    end

    // Sequencer, pipeline and architectural state.
    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase <= PH_T4;
            phase_o <= 4'h8;
            pc <= `MFS_RESET_VECTOR;
            ir <= 16'h0000;
            ir_valid <= 1'b0;
            pre <= 16'h0000;
            pre_valid <= 1'b0;
            acc <= 8'h00;
            mem_reg <= 8'h00;
            status <= `MFS_STATUS_RST;
            run <= `MFS_RUN_RST;
            emi <= `MFS_EMI_RST;
            tblp <= 8'h00;
            tbhp <= 3'h0;
            table_high_latch <= 8'h00;
            tbl_pend <= 1'b0;
            int_flag <= 1'b0;
            low_pend <= 1'b0;
            low_val <= 8'h00;
            pmem_addr_o <= `MFS_RESET_VECTOR;
            pmem_rd_o <= 1'b0;
            int_ack_o <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            phase_o <= ph_dec(next_phase);
            pmem_rd_o <= 1'b0;
            int_ack_o <= int_go;
            // Software writes; hardware updates below take precedence.
            if (wr_go && w_lane0)
            begin
                case (wa)
                    `MFS_REG_CTRL:
                    begin
                        run <= w_data[`MFS_CTRL_RUN];
                        emi <= w_data[`MFS_CTRL_EMI];
                    end
                    `MFS_REG_STATUS: status <= w_data[3:0];
                    `MFS_REG_PC_LOW:
                    begin
                        low_val <= w_data[7:0];
                        low_pend <= 1'b1;
                    end
                    `MFS_REG_TBLP: tblp <= w_data[7:0];
                    `MFS_REG_TBHP: tbhp <= w_data[2:0];
                    `MFS_REG_MEM: mem_reg <= w_data[7:0];
                    `MFS_REG_INTST:
                    begin
                        if (w_data[0])
                        begin
                            int_flag <= 1'b0;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            if (run && phase == PH_T4)
            begin
                pmem_rd_o <= 1'b1;
                if (tbl_pend)
                begin
                    pmem_addr_o <= {tbhp, tblp};
                    ir_valid <= 1'b0;
                end
                else
                begin
                    pmem_addr_o <= pc;
                    pc <= pc + 11'h001;
                    ir <= pre;
                    ir_valid <= pre_valid;
                end
            end
            // Word returned by program memory is taken at the end of T2.
            if (run && phase == PH_T2)
            begin
                if (tbl_pend)
                begin
                    acc <= pmem_rdata_i[7:0];
                    table_high_latch <= pmem_rdata_i[15:8];
                    tbl_pend <= 1'b0;
                end
                else
                begin
                    pre <= pmem_rdata_i;
                    pre_valid <= 1'b1;
                end
            end
            // Execute stage; a pending low-byte write replaces the slot.
            if (take_low)
            begin
                pc <= {pc[10:8], low_val};
                pre_valid <= 1'b0;
                low_pend <= low_wr;
            end
            else if (ex)
            begin
                case (cls)
                    `MFS_CL_ALUI:
                    begin
                        acc <= alu_res;
                        status <= alu_st;
                    end
                    `MFS_CL_ALUM:
                    begin
                        if (ir[0])
                        begin
                            mem_reg <= alu_res;
                        end
                        else
                        begin
                            acc <= alu_res;
                        end
                        status <= alu_st;
                    end
                    `MFS_CL_JUMP, `MFS_CL_CALL:
                    begin
                        pc <= ir[10:0];
                        pre_valid <= 1'b0;
                    end
                    `MFS_CL_RTN:
                    begin
                        pc <= stk_top;
                        pre_valid <= 1'b0;
                    end
                    `MFS_CL_RTNI:
                    begin
                        pc <= stk_top;
                        pre_valid <= 1'b0;
                        emi <= 1'b1;
                    end
                    `MFS_CL_SKZ, `MFS_CL_SKNZ:
                    begin
                        if (ir[7])
                        begin
                            mem_reg <= alu_res;
                        end
                        if (skip_taken)
                        begin
                            pre_valid <= 1'b0;
                        end
                    end
                    `MFS_CL_SETLOW:
                    begin
                        pc <= {pc[10:8], acc};
                        pre_valid <= 1'b0;
                    end
                    `MFS_CL_TABRD: tbl_pend <= 1'b1;
                    default:
                    begin
                    end
                endcase
                if (int_go)
                begin
                    pc <= INT_VECTOR;
                    pre_valid <= 1'b0;
                    emi <= 1'b0;
                    int_flag <= 1'b0;
                end
            end
            if (int_req_i)
            begin
                int_flag <= 1'b1;
            end
        end
    end
endmodule // mfs_top

// ---- tb/mfs_pmem_model.sv ----
`timescale 1ns/100ps
// Program store on the far side of the fetch port.
module mfs_pmem_model (
    input wire logic core_clk_i, // Clock.
    input wire logic pmem_rd_i, // Fetch strobe.
    input wire logic [10:0] pmem_addr_i, // Word address.
    output logic [15:0] pmem_rdata_o // Word returned.
);
    logic [15:0] mem [0:2047];
    logic hold = 1'b0;
    initial pmem_rdata_o = 16'h0000;
    // 2K word store
    // Holds the word for two cycles, then scrambles it so stale data is never reused.
    always @(posedge core_clk_i)
    begin
        hold <= pmem_rd_i;
        if (pmem_rd_i)
            pmem_rdata_o <= mem[pmem_addr_i];
        else if (!hold)
            pmem_rdata_o <= ~pmem_rdata_o;
    end
endmodule // mfs_pmem_model

// ---- tb/mfs_top_sva.sv ----
`timescale 1ns/100ps
`include "mfs_defs.vh"
module mfs_top_sva #(parameter [10:0] INT_VECTOR = 11'h004) (
    input wire core_clk_i, // Clock.
    input wire rst_n_i, // Reset.
    input wire [7:0] s_awaddr_i, // Write address.
    input wire s_awvalid_i, // Address valid.
    input wire s_awready_o, // Address ready.
    input wire [31:0] s_wdata_i, // Write data.
    input wire [3:0] s_wstrb_i, // Strobes.
    input wire s_wvalid_i, // Data valid.
    input wire s_wready_o, // Data ready.
    input wire [10:0] pmem_addr_o, // Fetch address.
    input wire pmem_rd_o, // Fetch strobe.
    input wire int_ack_o, // Acknowledge.
    input wire [3:0] phase_o // Phase.
);
    logic fresh;
    logic [2:0] pg;
    logic [7:0] wv;
    wire low_wr = s_awvalid_i && s_awready_o && s_awaddr_i == `MFS_REG_PC_LOW
        && s_wvalid_i && s_wready_o && s_wstrb_i[0];
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Marks the first edge after reset and records each low-byte write.
    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
        if (rst_n_i && low_wr)
        begin
            pg <= pmem_addr_o[10:8];
            wv <= s_wdata_i[7:0];
        end
    end
    sequence s_land;
        pmem_rd_o && pmem_addr_o == {pg, wv};
    endsequence
    sequence s_vec;
        pmem_rd_o && pmem_addr_o == INT_VECTOR;
    endsequence
    AST_PHASE_ONEHOT: assert property ($onehot(phase_o))
        else $error("phase not one-hot");
    AST_PHASE_STEP: assert property (phase_o == 4'h1 |=> phase_o == 4'h2)
        else $error("phase did not step");
    AST_FETCH_T1: assert property (pmem_rd_o == (phase_o == 4'h1))
        else $error("fetch outside first phase");
    AST_ADDR_HOLD: assert property (phase_o != 4'h1 |-> $stable(pmem_addr_o))
        else $error("fetch address moved");
    AST_RESET_VECTOR: assert property (fresh |=> pmem_rd_o && pmem_addr_o == 11'h000)
        else $error("no fetch at vector");
    AST_ACK_PULSE: assert property (int_ack_o |-> phase_o == 4'h8 ##1 !int_ack_o)
        else $error("bad acknowledge pulse");
    AST_ACK_VECTOR: assert property (int_ack_o |-> ##[1:9] s_vec)
        else $error("no jump to entry");
    AST_LOW_JUMP: assert property (low_wr |=> ##[0:11] s_land)
        else $error("no in-page jump");
endmodule // mfs_top_sva
bind mfs_top mfs_top_sva #(.INT_VECTOR(INT_VECTOR)) u_sva (.*);

// ---- tb/test_mfs_top.sv ----
`timescale 1ns/100ps
`include "mfs_defs.vh"
module test_mfs_top;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rnd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic int_req = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    wire awready, wready, bvalid, arready, rvalid, pmem_rd, int_ack;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [10:0] pmem_addr;
    wire [15:0] pmem_rdata;
    wire [3:0] phase;
    logic [33:0] rq[$];
    logic [10:0] fq[$];
    logic [1:0] bq[$];
    int failures = 0, samples_checked = 0, cyc = 0, acks = 0;
    localparam logic [31:0] PROG [22] = '{32'h0000_1400, 32'h0001_1505, 32'h0002_3010,
        32'h0003_15FF, 32'h0010_1002, 32'h0011_4020, 32'h0012_1510, 32'h0013_3013,
        32'h0020_1201, 32'h0021_7400, 32'h0022_15FF, 32'h0023_5000, 32'h0030_A000,
        32'h0031_1001, 32'h0032_0000, 32'h0033_3032, 32'h0004_1001, 32'h0005_6000,
        32'h0706_0F1A, 32'h0040_4050, 32'h0050_4060, 32'h0061_3060};
    localparam logic [10:0] FETCH [17] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h010,
        11'h011, 11'h012, 11'h020, 11'h021, 11'h022, 11'h023, 11'h024, 11'h012, 11'h013,
        11'h014, 11'h013, 11'h014};
    mfs_top #(.STACK_DEPTH(2)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
        .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready),
        .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr),
        .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
        .s_rvalid_o(rvalid), .s_rready_i(rready), .pmem_addr_o(pmem_addr), .pmem_rd_o(pmem_rd),
        .pmem_rdata_i(pmem_rdata), .int_req_i(int_req), .int_ack_o(int_ack), .phase_o(phase));
    mfs_pmem_model pm (.core_clk_i(core_clk_i), .pmem_rd_i(pmem_rd), .pmem_addr_i(pmem_addr),
        .pmem_rdata_o(pmem_rdata));
    // Free-running system clock.
    initial forever #5 core_clk_i = ~core_clk_i;
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = `MFS_RESP_OKAY);
        bq.push_back(r);
        @(posedge core_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        rq.push_back(exp);
        @(posedge core_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
    endtask
    // Compares each read answer, and each fetch address while fetch notes remain, with the oldest note.
    always @(posedge core_clk_i)
    begin
        if (int_ack) acks++;
        if (rvalid && rready)
            check({rresp, rdata}, rq.pop_front());
        if (bvalid && bready)
            check({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (rst_n_i && pmem_rd && fq.size() > 0)
            check({23'h0, pmem_addr}, {23'h0, fq.pop_front()});
    end
    // Cuts a hung run short.
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            failures++;
            finish_test();
        end
    end
    // Main sequence.
    initial
    begin
        foreach (pm.mem[i]) pm.mem[i] = 16'h0000;
        foreach (PROG[i]) pm.mem[PROG[i][26:16]] = PROG[i][15:0];
        foreach (FETCH[i]) fq.push_back(FETCH[i]);
        rnd = 8'($urandom(88482));
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        wait (fq.size() == 0);
        rd(`MFS_REG_ACC, 34'h16);
        $display("test flow done");
        wr(`MFS_REG_TBLP, 32'h06);
        wr(`MFS_REG_TBHP, 32'h07);
        wr(`MFS_REG_PC_LOW, 32'h30);
        wait (pmem_rd && pmem_addr == 11'h033);
        rd(`MFS_REG_ACC, 34'h1B);
        rd(`MFS_REG_TBL_HI, 34'h0F);
        $display("test table done");
        wr(`MFS_REG_CTRL, 32'h3);
        int_req <= 1'b1;
        @(posedge core_clk_i) int_req <= 1'b0;
        wait (acks == 1);
        wait (pmem_rd && pmem_addr == 11'h033);
        rd(`MFS_REG_ACC, 34'h1C);
        rd(`MFS_REG_CTRL, 34'h3);
        rd(`MFS_REG_INTST, 34'h0);
        check(34'(acks), 34'h1);
        $display("test interrupt done");
        // Two nested calls fill the stack, so a new request stays pending.
        wr(`MFS_REG_PC_LOW, 32'h40);
        wait (pmem_rd && pmem_addr == 11'h061);
        int_req <= 1'b1;
        @(posedge core_clk_i) int_req <= 1'b0;
        repeat (40) @(posedge core_clk_i);
        rd(`MFS_REG_INTST, 34'h1);
        check(34'(acks), 34'h1);
        $display("test stack done");
        wr(`MFS_REG_MEM, {24'h0, rnd});
        wstrb <= 4'h0;
        wr(`MFS_REG_MEM, {24'h0, ~rnd});
        wstrb <= 4'hF;
        rd(`MFS_REG_MEM, {26'h0, rnd});
        wr(8'h40, 32'h0, `MFS_RESP_SLVERR);
        rd(8'h40, {`MFS_RESP_SLVERR, 32'h0});
        $display("test register done");
        finish_test();
    end
endmodule // test_mfs_top
